// File: rtl/rfm_ref_setup.sv
// Notes on behaviour
// - Each nibble of a mask maps bit 0 loss of signal, 1 single cycle, 2 coarse freq, 3 soak.
// - A mask bit at zero disables its failure indicator and at one enables it.
// - A cleared mask bit suppresses only its own bit in the interrupt status at offset 0x02.
// - The sticky failure registers at 0x06 and 0x07 always see failures unmasked.
// - Register 0x08 holds the reference 2 mask in bits 3:0 and reference 3 in bits 7:4.
// - Register 0x09 holds the reference 0 mask low and the reference 1 mask high.
// - A set halving bit (bits 0 to 3) divides that reference clock by two toward the loop.
// - A clear halving bit passes that reference clock to the loop undivided.
// - Bits 4 to 7 of the input setup select differential reception on both pins when set.
// - A clear differential bit receives that reference single ended on its positive pin.
// - A 2-bit field per reference picks the disqualify delay: minimum, 10 ms, 50 ms, 2.5 s.
`timescale 1ns/1ps
module rfm_ref_setup
    import rfm_pkg::*;
#(
    parameter int DQ_10MS = DQ_10MS_CYCLES,
    parameter int DQ_50MS = DQ_50MS_CYCLES,
    parameter int DQ_2P5S = DQ_2P5S_CYCLES
) (
    input  wire logic                            ref_clk,
    input  wire logic                            rstn,
    input  wire logic [ADDR_WIDTH-1:0]           reg_addr,
    input  wire logic [REG_WIDTH-1:0]            reg_wdata,
    input  wire logic                            reg_write,
    input  wire logic                            reg_read,
    output logic      [REG_WIDTH-1:0]            reg_rdata,
    input  wire logic [REF_COUNT*FAIL_KINDS-1:0] failure_flags,
    output logic      [REF_COUNT*FAIL_KINDS-1:0] masked_failure,
    output logic      [REF_COUNT*FAIL_KINDS-1:0] unmasked_failure,
    input  wire logic [REF_COUNT-1:0]            input_positive_pin,
    input  wire logic [REF_COUNT-1:0]            input_negative_pin,
    output logic      [REF_COUNT-1:0]            pll_ref,
    output logic      [REF_COUNT-1:0]            disqualified
);

    logic [REG_WIDTH-1:0]            reference_failure_mask_upper;
    logic [REG_WIDTH-1:0]            reference_failure_mask_lower;
    logic [REG_WIDTH-1:0]            reference_input_setup;
    logic [REG_WIDTH-1:0]            soak_disqualify_delay;
    logic [REG_WIDTH-1:0]            next_mask_upper;
    logic [REG_WIDTH-1:0]            next_mask_lower;
    logic [REG_WIDTH-1:0]            next_input_setup;
    logic [REG_WIDTH-1:0]            next_dq_delay;
    logic [REG_WIDTH-1:0]            next_rdata;
    logic [REF_COUNT*FAIL_KINDS-1:0] failure_gate;
    logic [REF_COUNT*FAIL_KINDS-1:0] next_masked;
    logic [FAIL_KINDS-1:0]           input_a_failure_gate;
    logic [FAIL_KINDS-1:0]           input_b_failure_gate;
    logic [FAIL_KINDS-1:0]           input_c_failure_gate;
    logic [FAIL_KINDS-1:0]           input_d_failure_gate;
    logic                            reset_seen;

    // Register writes
    always_comb begin
        next_mask_upper  = reference_failure_mask_upper;
        next_mask_lower  = reference_failure_mask_lower;
        next_input_setup = reference_input_setup;
        next_dq_delay    = soak_disqualify_delay;
        if (reg_write) begin
            case (reg_addr)
                OFS_MASK_UPPER:  next_mask_upper  = reg_wdata;
                OFS_MASK_LOWER:  next_mask_lower  = reg_wdata;
                OFS_INPUT_SETUP: next_input_setup = reg_wdata;
                OFS_DQ_DELAY:    next_dq_delay    = reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // Read data held until next read; unmapped offsets read zero
    always_comb begin
        next_rdata = reg_rdata;
        if (reg_read) begin
            case (reg_addr)
                OFS_MASK_UPPER:  next_rdata = reference_failure_mask_upper;
                OFS_MASK_LOWER:  next_rdata = reference_failure_mask_lower;
                OFS_INPUT_SETUP: next_rdata = reference_input_setup;
                OFS_DQ_DELAY:    next_rdata = soak_disqualify_delay;
                default:         next_rdata = READ_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reference_failure_mask_upper <= RST_MASK_UPPER;
            reference_failure_mask_lower <= RST_MASK_LOWER;
            reference_input_setup        <= RST_INPUT_SETUP;
            soak_disqualify_delay        <= RST_DQ_DELAY;
            reg_rdata                    <= READ_IDLE;
        end else begin
            reference_failure_mask_upper <= next_mask_upper;
            reference_failure_mask_lower <= next_mask_lower;
            reference_input_setup        <= next_input_setup;
            soak_disqualify_delay        <= next_dq_delay;
            reg_rdata                    <= next_rdata;
        end
    end

    assign input_a_failure_gate = reference_failure_mask_lower[3:0];
    assign input_b_failure_gate = reference_failure_mask_lower[7:4];
    assign input_c_failure_gate = reference_failure_mask_upper[3:0];
    assign input_d_failure_gate = reference_failure_mask_upper[7:4];

    // Nibble order matches failure_flags: reference n at bits 4n+3:4n
    assign failure_gate = {input_d_failure_gate, input_c_failure_gate,
                           input_b_failure_gate, input_a_failure_gate};

    // Gating is bitwise so a cleared bit cannot hide a neighbour
    assign next_masked = failure_flags & failure_gate;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            masked_failure   <= '0;
            unmasked_failure <= '0;
        end else begin
            masked_failure   <= next_masked;
            unmasked_failure <= failure_flags;
        end
    end

    // Frequency settings elsewhere must assume the halved rate when enabled
    genvar gi;
    generate
        for (gi = 0; gi < REF_COUNT; gi++) begin : g_ref
            rfm_ref_path #(
                .DQ_10MS (DQ_10MS),
                .DQ_50MS (DQ_50MS),
                .DQ_2P5S (DQ_2P5S)
            ) u_path (
                .ref_clk                   (ref_clk),
                .rstn                      (rstn),
                .input_positive_pin        (input_positive_pin[gi]),
                .input_negative_pin        (input_negative_pin[gi]),
                .input_differential_select (reference_input_setup[DIFF_LSB+gi]),
                .input_halving_enable      (reference_input_setup[HALVE_LSB+gi]),
                .soak_failure              (failure_flags[gi*FAIL_KINDS+FAIL_SCM_BIT]
                                            | failure_flags[gi*FAIL_KINDS+FAIL_CFM_BIT]),
                .disqualify_delay_select   (soak_disqualify_delay[gi*DQ_SEL_WIDTH +: DQ_SEL_WIDTH]),
                .pll_ref                   (pll_ref[gi]),
                .disqualified              (disqualified[gi])
            );
        end
    endgenerate

    // Helper for the reset check
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reset_seen <= 1'b0;
        end else begin
            reset_seen <= 1'b1;
        end
    end

    property p_reset_setup;
        @(posedge ref_clk) disable iff (!rstn)
        !reset_seen |-> reference_input_setup == RST_INPUT_SETUP;
    endproperty
    a_reset_setup: assert property (p_reset_setup) else $error("input setup reset wrong");

    property p_los_map;
        @(posedge ref_clk) disable iff (!rstn)
        (failure_flags[FAIL_LOS_BIT] && reference_failure_mask_lower[FAIL_LOS_BIT])
            |=> masked_failure[FAIL_LOS_BIT];
    endproperty
    a_los_map: assert property (p_los_map) else $error("loss of signal not passed");

    property p_gst_map;
        @(posedge ref_clk) disable iff (!rstn)
        (failure_flags[12+FAIL_GST_BIT] && !reference_failure_mask_upper[4+FAIL_GST_BIT])
            |=> !masked_failure[12+FAIL_GST_BIT];
    endproperty
    a_gst_map: assert property (p_gst_map) else $error("masked soak failure leaked");

    property p_only_own_bit;
        @(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> masked_failure == ($past(failure_flags)
            & {$past(reference_failure_mask_upper), $past(reference_failure_mask_lower)});
    endproperty
    a_only_own_bit: assert property (p_only_own_bit) else $error("mask gating wrong");

    property p_sticky_unmasked;
        @(posedge ref_clk) disable iff (!rstn)
        (failure_flags != '0) |=> (unmasked_failure | masked_failure) == unmasked_failure
            && unmasked_failure == $past(failure_flags);
    endproperty
    a_sticky_unmasked: assert property (p_sticky_unmasked) else $error("sticky path masked");

    property p_write_upper;
        @(posedge ref_clk) disable iff (!rstn)
        (reg_write && reg_addr == OFS_MASK_UPPER) |=>
            input_c_failure_gate == $past(reg_wdata[3:0])
            && input_d_failure_gate == $past(reg_wdata[7:4]);
    endproperty
    a_write_upper: assert property (p_write_upper) else $error("upper mask write lost");

    property p_write_lower;
        @(posedge ref_clk) disable iff (!rstn)
        (reg_write && reg_addr == OFS_MASK_LOWER) |=>
            input_a_failure_gate == $past(reg_wdata[3:0])
            && input_b_failure_gate == $past(reg_wdata[7:4]);
    endproperty
    a_write_lower: assert property (p_write_lower) else $error("lower mask write lost");

    property p_write_setup;
        @(posedge ref_clk) disable iff (!rstn)
        (reg_write && reg_addr == OFS_INPUT_SETUP) |=> reference_input_setup == $past(reg_wdata);
    endproperty
    a_write_setup: assert property (p_write_setup) else $error("input setup write lost");

    property p_read_setup;
        @(posedge ref_clk) disable iff (!rstn)
        (reg_read && reg_addr == OFS_INPUT_SETUP && !reg_write)
            |=> reg_rdata == $past(reference_input_setup);
    endproperty
    a_read_setup: assert property (p_read_setup) else $error("input setup read wrong");

    property p_read_unmapped;
        @(posedge ref_clk) disable iff (!rstn)
        (reg_read && reg_addr != OFS_MASK_UPPER && reg_addr != OFS_MASK_LOWER
            && reg_addr != OFS_INPUT_SETUP && reg_addr != OFS_DQ_DELAY) |=> reg_rdata == READ_IDLE;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

endmodule

// File: rtl/rfm_pkg.sv
package rfm_pkg;

    localparam int          REF_COUNT       = 4;
    localparam int          FAIL_KINDS      = 4;
    localparam int          REG_WIDTH       = 8;
    localparam int          ADDR_WIDTH      = 8;

    // Register offsets
    localparam logic [7:0]  OFS_MASK_UPPER  = 8'h08;
    localparam logic [7:0]  OFS_MASK_LOWER  = 8'h09;
    localparam logic [7:0]  OFS_INPUT_SETUP = 8'h0A;
    localparam logic [7:0]  OFS_DQ_DELAY    = 8'h0B;

    // Reset values
    localparam logic [7:0]  RST_MASK_UPPER  = 8'h66;
    localparam logic [7:0]  RST_MASK_LOWER  = 8'h66;
    localparam logic [7:0]  RST_INPUT_SETUP = 8'h10;
    localparam logic [7:0]  RST_DQ_DELAY    = 8'hAA;
    localparam logic [7:0]  READ_IDLE       = 8'h00;

    // Failure kind positions within a nibble
    localparam int          FAIL_LOS_BIT    = 0;
    localparam int          FAIL_SCM_BIT    = 1;
    localparam int          FAIL_CFM_BIT    = 2;
    localparam int          FAIL_GST_BIT    = 3;

    // Input setup field positions
    localparam int          HALVE_LSB       = 0;
    localparam int          DIFF_LSB        = 4;

    // Disqualify delay field
    localparam int          DQ_SEL_WIDTH    = 2;
    localparam logic [1:0]  DQ_SEL_MIN      = 2'h0;
    localparam logic [1:0]  DQ_SEL_10MS     = 2'h1;
    localparam logic [1:0]  DQ_SEL_50MS     = 2'h2;
    localparam logic [1:0]  DQ_SEL_2P5S     = 2'h3;

    // Timing
    localparam int          CLK_FREQ_KHZ    = 100000;
    localparam int          DQ_10MS_MS      = 10;
    localparam int          DQ_50MS_MS      = 50;
    localparam int          DQ_2P5S_MS      = 2500;
    localparam int          DQ_MIN_CYCLES   = 1;
    localparam int          DQ_10MS_CYCLES  = DQ_10MS_MS * CLK_FREQ_KHZ;
    localparam int          DQ_50MS_CYCLES  = DQ_50MS_MS * CLK_FREQ_KHZ;
    localparam int          DQ_2P5S_CYCLES  = DQ_2P5S_MS * CLK_FREQ_KHZ;
    localparam int          DQ_CNT_WIDTH    = 28;

    typedef enum logic [2:0] {
        RFM_QUALIFIED    = 3'b001,
        RFM_SOAKING      = 3'b010,
        RFM_DISQUALIFIED = 3'b100
    } rfm_dq_state_type;

endpackage

// File: rtl/rfm_ref_path.sv
`timescale 1ns/1ps
module rfm_ref_path
    import rfm_pkg::*;
#(
    parameter int DQ_10MS = DQ_10MS_CYCLES,
    parameter int DQ_50MS = DQ_50MS_CYCLES,
    parameter int DQ_2P5S = DQ_2P5S_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        input_positive_pin,
    input  wire logic        input_negative_pin,
    input  wire logic        input_differential_select,
    input  wire logic        input_halving_enable,
    input  wire logic        soak_failure,
    input  wire logic [1:0]  disqualify_delay_select,
    output logic             pll_ref,
    output logic             disqualified
);

    logic                    pos_meta;
    logic                    pos_sync;
    logic                    neg_meta;
    logic                    neg_sync;
    logic                    level;
    logic                    level_prev;
    logic                    halved;
    logic                    next_halved;
    logic                    next_pll_ref;
    rfm_dq_state_type        state;
    rfm_dq_state_type        next_state;
    logic [DQ_CNT_WIDTH-1:0] count;
    logic [DQ_CNT_WIDTH-1:0] next_count;
    logic [DQ_CNT_WIDTH-1:0] limit;

    // Pins are asynchronous to ref_clk
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pos_meta <= 1'b0;
            pos_sync <= 1'b0;
            neg_meta <= 1'b0;
            neg_sync <= 1'b0;
        end else begin
            pos_meta <= input_positive_pin;
            pos_sync <= pos_meta;
            neg_meta <= input_negative_pin;
            neg_sync <= neg_meta;
        end
    end

    // Negative pin ignored when single ended
    assign level = input_differential_select ? (pos_sync & ~neg_sync) : pos_sync;

    always_comb begin
        next_halved = halved;
        if (level && !level_prev) begin
            next_halved = ~halved;
        end
        next_pll_ref = input_halving_enable ? halved : level;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            level_prev <= 1'b0;
            halved     <= 1'b0;
            pll_ref    <= 1'b0;
        end else begin
            level_prev <= level;
            halved     <= next_halved;
            pll_ref    <= next_pll_ref;
        end
    end

    always_comb begin
        case (disqualify_delay_select)
            DQ_SEL_MIN:  limit = DQ_CNT_WIDTH'(DQ_MIN_CYCLES);
            DQ_SEL_10MS: limit = DQ_CNT_WIDTH'(DQ_10MS);
            DQ_SEL_50MS: limit = DQ_CNT_WIDTH'(DQ_50MS);
            default:     limit = DQ_CNT_WIDTH'(DQ_2P5S);
        endcase
    end

    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            RFM_QUALIFIED: begin
                if (soak_failure) begin
                    next_state = RFM_SOAKING;
                    next_count = DQ_CNT_WIDTH'(1);
                end
            end
            RFM_SOAKING: begin
                if (!soak_failure) begin
                    next_state = RFM_QUALIFIED;
                end else if (count >= limit) begin
                    next_state = RFM_DISQUALIFIED;
                end else begin
                    next_count = count + DQ_CNT_WIDTH'(1);
                end
            end
            RFM_DISQUALIFIED: begin
                if (!soak_failure) begin
                    next_state = RFM_QUALIFIED;
                end
            end
            default: begin
                next_state = RFM_QUALIFIED;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= RFM_QUALIFIED;
            count <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    assign disqualified = (state == RFM_DISQUALIFIED);

    property p_halve_toggle;
        @(posedge ref_clk) disable iff (!rstn)
        (input_halving_enable && level && !level_prev) ##1 input_halving_enable
            |=> pll_ref != $past(pll_ref);
    endproperty
    a_halve_toggle: assert property (p_halve_toggle) else $error("halved clock missed a toggle");

    property p_direct_path;
        @(posedge ref_clk) disable iff (!rstn)
        !input_halving_enable |=> pll_ref == $past(level);
    endproperty
    a_direct_path: assert property (p_direct_path) else $error("undivided path mismatch");

    property p_min_delay;
        @(posedge ref_clk) disable iff (!rstn)
        (state == RFM_QUALIFIED && soak_failure && disqualify_delay_select == DQ_SEL_MIN)
            ##1 (soak_failure && disqualify_delay_select == DQ_SEL_MIN) |=> disqualified;
    endproperty
    a_min_delay: assert property (p_min_delay) else $error("minimum disqualify too slow");

endmodule

// File: verif/rfm_ref_source.sv
`timescale 1ns/1ps
module rfm_ref_source
    import rfm_pkg::*;
#(
    parameter int HALF_PERIOD = 4
) (
    input  wire logic                 ref_clk,
    input  wire logic [REF_COUNT-1:0] run,
    input  wire logic [REF_COUNT-1:0] diff_mode,
    input  wire logic                 common_mode,
    output logic      [REF_COUNT-1:0] pos_pin,
    output logic      [REF_COUNT-1:0] neg_pin
);
    logic [REF_COUNT-1:0] level;
    int                   phase;

    initial begin
        level = '0;
        phase = 0;
    end

    // Stopped sources stand low, never a stale level
    always @(negedge ref_clk) begin
        phase = (phase + 1) % HALF_PERIOD;
        if (phase == 0) begin
            level = ~level & run;
        end else begin
            level = level & run;
        end
    end

    // Single ended wiring grounds the negative pin; common mode only on command
    assign pos_pin = level;
    assign neg_pin = diff_mode & (common_mode ? level : ~level);
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))
module tb_top
    import rfm_pkg::*;
;
    logic        ref_clk;
    logic        rstn;
    logic        reg_write;
    logic        reg_read;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic [15:0] failure_flags;
    logic [15:0] masked_failure;
    logic [15:0] unmasked_failure;
    logic [3:0]  pos_pin;
    logic [3:0]  neg_pin;
    logic [3:0]  pll_ref;
    logic [3:0]  disqualified;
    logic [3:0]  run;
    logic [3:0]  diff_mode;
    logic        common_mode;
    int          err_count;
    int          tests_run;

    rfm_ref_setup #(.DQ_10MS(10), .DQ_50MS(20), .DQ_2P5S(40)) DUT (
        .ref_clk            (ref_clk),
        .rstn               (rstn),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_write          (reg_write),
        .reg_read           (reg_read),
        .reg_rdata          (reg_rdata),
        .failure_flags      (failure_flags),
        .masked_failure     (masked_failure),
        .unmasked_failure   (unmasked_failure),
        .input_positive_pin (pos_pin),
        .input_negative_pin (neg_pin),
        .pll_ref            (pll_ref),
        .disqualified       (disqualified)
    );

    rfm_ref_source #(.HALF_PERIOD(4)) source (
        .ref_clk     (ref_clk),
        .run         (run),
        .diff_mode   (diff_mode),
        .common_mode (common_mode),
        .pos_pin     (pos_pin),
        .neg_pin     (neg_pin)
    );

    always #5 ref_clk = ~ref_clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("Checks made %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Strobes stay up between back-to-back calls so no signal is driven twice per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_read  = 1'b0;
        reg_write = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_write = 1'b0;
        reg_read  = 1'b1;
        reg_addr  = a;
        @(negedge ref_clk);
        `CHK(reg_rdata, e);
    endtask

    task automatic idle();
        reg_write = 1'b0;
        reg_read  = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic end_test(input string name);
        idle();
        $display("Test %s done, mismatches so far %0d", name, err_count);
    endtask

    // Edge counts depend on source phase, so one edge of slack is allowed
    function automatic int near(input int c, input int e);
        return (c >= e - 1 && c <= e + 1) ? e : c;
    endfunction

    task automatic masks(input logic [7:0] up, input logic [7:0] lo);
        logic [15:0] m;
        m = {up, lo};
        wr(OFS_MASK_UPPER, up);
        wr(OFS_MASK_LOWER, lo);
        idle();
        for (int b = 0; b < 16; b++) begin
            failure_flags = 16'h0001 << b;
            @(negedge ref_clk);
            `CHK(masked_failure, m & (16'h0001 << b));
            `CHK(unmasked_failure, 16'h0001 << b);
        end
        failure_flags = 16'hFFFF;
        @(negedge ref_clk);
        `CHK(masked_failure, m);
        failure_flags = 16'h0000;
        @(negedge ref_clk);
    endtask

    task automatic measure(input logic [7:0] cfg, input logic cm);
        logic [3:0] prev;
        int         cnt [4];
        int         e;
        wr(OFS_INPUT_SETUP, cfg);
        idle();
        diff_mode   = cfg[7:4];
        common_mode = cm;
        run         = 4'hF;
        repeat (20) @(negedge ref_clk);
        prev = pll_ref;
        cnt  = '{0, 0, 0, 0};
        repeat (160) begin
            @(negedge ref_clk);
            for (int i = 0; i < 4; i++) cnt[i] += int'(pll_ref[i] & ~prev[i]);
            prev = pll_ref;
        end
        for (int i = 0; i < 4; i++) begin
            e = (cfg[4+i] && cm) ? 0 : (cfg[i] ? 10 : 20);
            `CHK(near(cnt[i], e), e);
        end
    endtask

    task automatic disq(input logic [1:0] sel, input int lim);
        int n;
        wr(OFS_DQ_DELAY, {4{sel}});
        idle();
        failure_flags = 16'h4242;
        n = 0;
        while (disqualified !== 4'hF && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(near(n, lim + 1), lim + 1);
        failure_flags = 16'h0000;
        repeat (4) @(negedge ref_clk);
        `CHK(disqualified, 4'h0);
    endtask

    initial begin
        ref_clk       = 1'b0;
        rstn          = 1'b0;
        reg_write     = 1'b0;
        reg_read      = 1'b0;
        reg_addr      = 8'h00;
        reg_wdata     = 8'h00;
        failure_flags = 16'h0000;
        run           = 4'h0;
        diff_mode     = 4'h1;
        common_mode   = 1'b0;
        err_count     = 0;
        tests_run     = 0;
        repeat (5) @(negedge ref_clk);
        rstn = 1'b1;
        @(negedge ref_clk);
        rd(OFS_MASK_UPPER, RST_MASK_UPPER);
        rd(OFS_MASK_LOWER, RST_MASK_LOWER);
        rd(OFS_INPUT_SETUP, RST_INPUT_SETUP);
        rd(OFS_DQ_DELAY, RST_DQ_DELAY);
        wr(8'h0C, 8'hFF);
        wr(8'h07, 8'hFF);
        rd(8'h0C, READ_IDLE);
        rd(8'h07, READ_IDLE);
        rd(OFS_MASK_UPPER, RST_MASK_UPPER);
        end_test("reset values");
        for (int v = 0; v < 2; v++) begin
            for (int r = 0; r < 4; r++) wr(OFS_MASK_UPPER + 8'(r), 8'hA5 ^ 8'(v * 255 + r));
            for (int r = 0; r < 4; r++) rd(OFS_MASK_UPPER + 8'(r), 8'hA5 ^ 8'(v * 255 + r));
        end
        end_test("register access");
        masks(8'hA5, 8'h3C);
        masks(8'h5A, 8'hC3);
        end_test("failure gating");
        measure(8'h00, 1'b0);
        measure(8'h0F, 1'b0);
        measure(8'hA5, 1'b0);
        measure(8'hF0, 1'b1);
        measure(8'h00, 1'b1);
        measure(8'h5A, 1'b1);
        end_test("reference path");
        disq(DQ_SEL_MIN, 1);
        disq(DQ_SEL_10MS, 10);
        disq(DQ_SEL_50MS, 20);
        disq(DQ_SEL_2P5S, 40);
        // A failure that drops mid-soak restarts the delay
        wr(OFS_DQ_DELAY, 8'h55);
        idle();
        failure_flags = 16'h4242;
        repeat (5) @(negedge ref_clk);
        `CHK(disqualified, 4'h0);
        failure_flags = 16'h9999;
        repeat (30) @(negedge ref_clk);
        `CHK(disqualified, 4'h0);
        failure_flags = 16'h4242;
        repeat (10) @(negedge ref_clk);
        `CHK(disqualified, 4'h0);
        @(negedge ref_clk);
        `CHK(disqualified, 4'hF);
        failure_flags = 16'h0000;
        end_test("disqualify delay");
        rstn = 1'b0;
        @(negedge ref_clk);
        rstn = 1'b1;
        @(negedge ref_clk);
        rd(OFS_INPUT_SETUP, RST_INPUT_SETUP);
        rd(OFS_MASK_LOWER, RST_MASK_LOWER);
        end_test("second reset");
        close_out();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        close_out();
    end
endmodule
